/* File: include/timer2_pkg.sv */
package timer2_pkg;

    // Register indices; byte address is four times the index
    localparam logic [9:0]  TIMER_CONTROL_IDX   = 10'h0c8;
    localparam logic [9:0]  TIMER_MODE_IDX      = 10'h0c9;
    localparam logic [9:0]  CAP_LOW_IDX         = 10'h0ca;
    localparam logic [9:0]  CAP_HIGH_IDX        = 10'h0cb;
    localparam logic [9:0]  COUNT_LOW_IDX       = 10'h0cc;
    localparam logic [9:0]  COUNT_HIGH_IDX      = 10'h0cd;
    localparam logic [9:0]  CLOCK_CONTROL_IDX   = 10'h0df;
    localparam logic [9:0]  OPTION_IDX          = 10'h100;
    localparam logic [9:0]  UNLOCK_IDX          = 10'h101;
    localparam logic [9:0]  IRQ_STATUS_IDX      = 10'h102;
    localparam logic [9:0]  IRQ_CLEAR_IDX       = 10'h103;
    localparam logic [9:0]  IRQ_ENABLE_IDX      = 10'h104;

    // Timer control fields
    localparam int CR_SELECT_BIT  = 0;
    localparam int COUNTER_BIT    = 1;
    localparam int RUN_BIT        = 2;
    localparam int EXT_ENABLE_BIT = 3;
    localparam int TX_BAUD_BIT    = 4;
    localparam int RX_BAUD_BIT    = 5;
    localparam logic [7:0] TIMER_CONTROL_MASK = 8'h3f;

    // Timer mode fields
    localparam int DOWN_ENABLE_BIT = 0;
    localparam int CLKOUT_BIT      = 1;
    localparam logic [7:0] TIMER_MODE_MASK = 8'h03;

    // Clock control fields; only bits 5, 4, 3 and 0 exist
    localparam int PRESCALE_BIT = 5;
    localparam logic [7:0] CLOCK_CONTROL_MASK  = 8'h39;
    localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h01;

    // Option register: bit 3 forces 12 clocks per machine cycle
    localparam int TWELVE_CLOCK_BIT = 3;
    localparam logic [7:0] OPTION_MASK = 8'h08;

    // Interrupt status layout
    localparam int OVF_FLAG_BIT = 0;
    localparam int EXT_FLAG_BIT = 1;

    // Timed-access unlock
    localparam logic [7:0] UNLOCK_KEY_FIRST  = 8'haa;
    localparam logic [7:0] UNLOCK_KEY_SECOND = 8'h55;
    localparam logic [3:0] UNLOCK_WINDOW     = 4'h8;

    // Prescaler divide counts
    localparam logic [3:0] DIV_SHORT = 4'h6;
    localparam logic [3:0] DIV_LONG  = 4'hc;

    localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;

    typedef enum logic [1:0] {
        UNLOCK_IDLE,
        UNLOCK_FIRST,
        UNLOCK_OPEN
    } unlock_state_t;

endpackage

/* File: rtl/prescale_divider.sv */
module prescale_divider
    import timer2_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic divide_long,
    output logic      tick
);

    logic [3:0] count;
    logic [3:0] next_count;
    logic       next_tick;
    logic [3:0] limit;

    always_comb begin
        limit      = divide_long ? DIV_LONG : DIV_SHORT;
        next_tick  = 1'b0;
        next_count = count + 4'h1;
        if (count >= limit - 4'h1) begin
            next_count = 4'h0;
            next_tick  = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 4'h0;
            tick  <= 1'b0;
        end else begin
            count <= next_count;
            tick  <= next_tick;
        end
    end

endmodule

/* File: rtl/timer2_reload_capture.sv */
// Functional notes
// - Mode bit 1 enables the clock-out function on its pin, clear disables it.
// - With down-count enable set in auto-reload mode the trigger pin level picks up or down.
// - A capture event copies the low count byte into the low capture register.
// - The same capture event copies the high count byte into the high capture register.
// - Auto-reload loads the counter from the high and low capture bytes as one 16-bit value.
// - Prescale select picks core clock divided by 6 when 0 and by 12 when 1.
// - The twelve-clock option bit overrides prescale select and forces divide by 12.
// - Clock control always reads, but a write lands only after the unlock sequence.
// - With both baud selects clear, overflow or down-count match sets the overflow flag.
// - A trigger falling edge with external enable and down-count off sets the external flag.
// - Select 0 reloads on overflow or trigger edge, select 1 captures on trigger edge.
// - Run control starts counting; clearing it stops counting, but a trigger-edge reload still loads both count bytes.
module timer2_reload_capture
    import timer2_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        external_trigger_pin,
    output logic             clock_out_pin,
    output logic             clock_out_oe,
    output logic             irq
);

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    logic [9:0]  index;
    logic        wr_en;
    logic        known;
    logic [31:0] rd_value;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic [7:0]  wbyte;

    assign index = paddr[11:2];
    assign wbyte = pwdata[7:0];
    // Writes land only on the access edge that completes the transfer
    assign wr_en = psel & penable & pwrite & pready;

    logic [15:0]   count;
    logic [7:0]    cap_low;
    logic [7:0]    cap_high;
    logic [7:0]    timer_control;
    logic [7:0]    timer_mode;
    logic [7:0]    clock_control;
    logic [7:0]    option;
    logic [1:0]    irq_status;
    logic [1:0]    irq_enable;
    unlock_state_t unlock_state;
    logic [3:0]    unlock_timer;

    always_comb begin
        known    = 1'b1;
        rd_value = 32'h0000_0000;
        case (index)
            TIMER_CONTROL_IDX: rd_value[7:0] = timer_control;
            TIMER_MODE_IDX:    rd_value[7:0] = timer_mode;
            CAP_LOW_IDX:       rd_value[7:0] = cap_low;
            CAP_HIGH_IDX:      rd_value[7:0] = cap_high;
            COUNT_LOW_IDX:     rd_value[7:0] = count[7:0];
            COUNT_HIGH_IDX:    rd_value[7:0] = count[15:8];
            CLOCK_CONTROL_IDX: rd_value[7:0] = clock_control;
            OPTION_IDX:        rd_value[7:0] = option;
            UNLOCK_IDX:        rd_value = 32'h0000_0000;
            IRQ_STATUS_IDX:    rd_value[1:0] = irq_status;
            IRQ_CLEAR_IDX:     rd_value = 32'h0000_0000;
            IRQ_ENABLE_IDX:    rd_value[1:0] = irq_enable;
            default:           known = 1'b0;
        endcase
        // Zero-wait slave: ready rises in the first access cycle
        next_pready  = psel & ~penable;
        next_prdata  = (psel & ~penable & ~pwrite) ? rd_value : prdata;
        next_pslverr = psel & ~penable & ~known;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ----------------------------------------------------------------
    // Trigger pin synchroniser and prescaler
    // ----------------------------------------------------------------
    logic ext_meta;
    logic ext_sync;
    logic ext_prev;
    logic ext_fall;
    logic tick;
    logic divide_long;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_meta <= 1'b1;
            ext_sync <= 1'b1;
            ext_prev <= 1'b1;
        end else begin
            ext_meta <= external_trigger_pin;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
        end
    end

    assign ext_fall = ext_prev & ~ext_sync;

    // prescale select picks the divide ratio
    // twelve-clock option forces the long divide
    assign divide_long = clock_control[PRESCALE_BIT] | option[TWELVE_CLOCK_BIT];

    prescale_divider u_divider (
        .pclk        (pclk),
        .presetn     (presetn),
        .divide_long (divide_long),
        .tick        (tick)
    );

    // ----------------------------------------------------------------
    // Counter core
    // ----------------------------------------------------------------
    logic          baud;
    logic          cr_select;
    logic          ext_enable;
    logic          down_mode;
    logic          count_up;
    logic          cnt_en;
    logic          up_ovf;
    logic          down_match;
    logic          reload;
    logic          capture;
    logic [15:0]   next_count;
    logic [7:0]    next_cap_low;
    logic [7:0]    next_cap_high;
    logic [7:0]    next_timer_control;
    logic [7:0]    next_timer_mode;
    logic [7:0]    next_clock_control;
    logic [7:0]    next_option;
    logic [1:0]    next_irq_status;
    logic [1:0]    next_irq_enable;
    logic [1:0]    set_flags;
    unlock_state_t next_unlock_state;
    logic [3:0]    next_unlock_timer;
    logic          next_clock_out_pin;
    logic          next_clock_out_oe;
    logic          next_irq;

    always_comb begin
        baud       = timer_control[TX_BAUD_BIT] | timer_control[RX_BAUD_BIT];
        cr_select  = timer_control[CR_SELECT_BIT] & ~baud;
        ext_enable = timer_control[EXT_ENABLE_BIT] & ~baud;
        // trigger level steers direction only in auto-reload with down-count
        down_mode  = timer_mode[DOWN_ENABLE_BIT] & ~cr_select & ~baud;
        count_up   = ~down_mode | ext_sync;
        // nothing advances while run control is clear
        cnt_en     = timer_control[RUN_BIT] & (timer_control[COUNTER_BIT] ? ext_fall : tick);
        up_ovf     = cnt_en & count_up & (count == COUNT_ALL_ONES);
        down_match = cnt_en & ~count_up & (count == {cap_high, cap_low});
        // select 0 reloads on overflow or edge, select 1 captures on edge
        reload     = ~cr_select & (up_ovf | (ext_fall & ext_enable & ~down_mode));
        capture    = cr_select & ext_fall & ext_enable;

        next_count = count;
        if (reload) begin
            // reload from the capture bytes, high byte on top
            next_count = {cap_high, cap_low};
        end else if (down_match) begin
            next_count = COUNT_ALL_ONES;
        end else if (cnt_en) begin
            // carry ripples from the low byte into the high byte
            next_count = count_up ? count + 16'h0001 : count - 16'h0001;
        end

        next_cap_low  = cap_low;
        next_cap_high = cap_high;
        if (capture) begin
            next_cap_low  = count[7:0];
            // high byte captured in the same event
            next_cap_high = count[15:8];
        end

        // overflow flag held off in baud-rate use
        set_flags[OVF_FLAG_BIT] = ~baud & (up_ovf | down_match);
        // falling edge sets the external flag when down-count is off
        set_flags[EXT_FLAG_BIT] = ext_fall & ext_enable & ~timer_mode[DOWN_ENABLE_BIT];

        next_timer_control = timer_control;
        next_timer_mode    = timer_mode;
        next_clock_control = clock_control;
        next_option        = option;
        next_irq_enable    = irq_enable;
        next_irq_status    = irq_status;
        next_unlock_state  = unlock_state;
        next_unlock_timer  = unlock_timer;

        if (unlock_state == UNLOCK_OPEN) begin
            next_unlock_timer = unlock_timer - 4'h1;
            if (unlock_timer == 4'h1) begin
                next_unlock_state = UNLOCK_IDLE;
            end
        end

        if (wr_en) begin
            case (index)
                TIMER_CONTROL_IDX: next_timer_control = wbyte & TIMER_CONTROL_MASK;
                TIMER_MODE_IDX:    next_timer_mode    = wbyte & TIMER_MODE_MASK;
                CAP_LOW_IDX:       next_cap_low       = wbyte;
                CAP_HIGH_IDX:      next_cap_high      = wbyte;
                COUNT_LOW_IDX:     next_count[7:0]    = wbyte;
                COUNT_HIGH_IDX:    next_count[15:8]   = wbyte;
                OPTION_IDX:        next_option        = wbyte & OPTION_MASK;
                IRQ_ENABLE_IDX:    next_irq_enable    = wbyte[1:0];
                IRQ_CLEAR_IDX:     next_irq_status    = irq_status & ~wbyte[1:0];
                CLOCK_CONTROL_IDX: begin
                    // a write lands only inside the unlock window
                    if (unlock_state == UNLOCK_OPEN) begin
                        next_clock_control = wbyte & CLOCK_CONTROL_MASK;
                    end
                    next_unlock_state = UNLOCK_IDLE;
                end
                UNLOCK_IDX: begin
                    case (unlock_state)
                        UNLOCK_FIRST: next_unlock_state = (wbyte == UNLOCK_KEY_SECOND)
                                                          ? UNLOCK_OPEN : UNLOCK_IDLE;
                        default:      next_unlock_state = (wbyte == UNLOCK_KEY_FIRST)
                                                          ? UNLOCK_FIRST : UNLOCK_IDLE;
                    endcase
                    next_unlock_timer = UNLOCK_WINDOW;
                end
                default: ;
            endcase
        end
        // Hardware set wins over a clear in the same cycle
        next_irq_status = next_irq_status | set_flags;

        // clock-out toggles on each wrap while enabled
        next_clock_out_oe  = next_timer_mode[CLKOUT_BIT];
        next_clock_out_pin = timer_mode[CLKOUT_BIT] ? clock_out_pin ^ (up_ovf | down_match)
                                                    : 1'b0;
        next_irq = |(next_irq_status & next_irq_enable);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count         <= 16'h0000;
            cap_low       <= 8'h00;
            cap_high      <= 8'h00;
            timer_control <= 8'h00;
            timer_mode    <= 8'h00;
            clock_control <= CLOCK_CONTROL_RESET;
            option        <= 8'h00;
            irq_status    <= 2'b00;
            irq_enable    <= 2'b00;
            unlock_state  <= UNLOCK_IDLE;
            unlock_timer  <= 4'h0;
            clock_out_pin <= 1'b0;
            clock_out_oe  <= 1'b0;
            irq           <= 1'b0;
        end else begin
            count         <= next_count;
            cap_low       <= next_cap_low;
            cap_high      <= next_cap_high;
            timer_control <= next_timer_control;
            timer_mode    <= next_timer_mode;
            clock_control <= next_clock_control;
            option        <= next_option;
            irq_status    <= next_irq_status;
            irq_enable    <= next_irq_enable;
            unlock_state  <= next_unlock_state;
            unlock_timer  <= next_unlock_timer;
            clock_out_pin <= next_clock_out_pin;
            clock_out_oe  <= next_clock_out_oe;
            irq           <= next_irq;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    logic sw_count_wr;
    assign sw_count_wr = wr_en & ((index == COUNT_LOW_IDX) | (index == COUNT_HIGH_IDX));

    a_clkout_gate: assert property (
        @(posedge pclk) disable iff (!presetn)
        !timer_mode[CLKOUT_BIT] |-> !clock_out_oe ##1 !clock_out_pin)
        else $error("clock-out active while disabled");

    a_down_direction: assert property (
        @(posedge pclk) disable iff (!presetn)
        cnt_en && down_mode && !ext_sync && !down_match && !sw_count_wr
        |=> count == $past(count) - 16'h0001)
        else $error("down count did not decrement");

    a_capture_low: assert property (
        @(posedge pclk) disable iff (!presetn)
        capture && !wr_en |=> cap_low == $past(count[7:0]))
        else $error("low capture byte wrong");

    a_capture_high: assert property (
        @(posedge pclk) disable iff (!presetn)
        capture && !wr_en |=> cap_high == $past(count[15:8]))
        else $error("high capture byte wrong");

    a_reload_value: assert property (
        @(posedge pclk) disable iff (!presetn)
        up_ovf && !cr_select && !wr_en |=> count == {$past(cap_high), $past(cap_low)})
        else $error("reload value wrong");

    a_prescale_six: assert property (
        @(posedge pclk) disable iff (!presetn)
        tick && !clock_control[PRESCALE_BIT] && !option[TWELVE_CLOCK_BIT] && !wr_en
        ##1 !wr_en |-> !tick [*5])
        else $error("divide-by-6 tick spacing wrong");

    a_twelve_forced: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(tick) && option[TWELVE_CLOCK_BIT] |=> !tick [*8])
        else $error("twelve-clock option not honoured");

    a_prescale_locked: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_en && index == CLOCK_CONTROL_IDX && unlock_state != UNLOCK_OPEN
        |=> $stable(clock_control))
        else $error("clock control written while locked");

    a_ovf_flag: assert property (
        @(posedge pclk) disable iff (!presetn)
        up_ovf && !baud |=> irq_status[OVF_FLAG_BIT])
        else $error("overflow flag not set");

    a_ext_flag: assert property (
        @(posedge pclk) disable iff (!presetn)
        ext_fall && ext_enable && !timer_mode[DOWN_ENABLE_BIT] |=> irq_status[EXT_FLAG_BIT])
        else $error("external flag not set");

    a_hold_stopped: assert property (
        @(posedge pclk) disable iff (!presetn)
        !timer_control[RUN_BIT] && !sw_count_wr && !reload |=> $stable(count))
        else $error("count moved while stopped");

    a_count_step: assert property (
        @(posedge pclk) disable iff (!presetn)
        cnt_en && count_up && !up_ovf && !reload && !sw_count_wr
        |=> count == $past(count) + 16'h0001)
        else $error("count did not advance by one");

endmodule

/* File: dv/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import timer2_pkg::*;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        trig;
    logic        clock_out_pin;
    logic        clock_out_oe;
    logic        irq;
    logic [32:0] exp_q[$];
    int          miscompares;
    int          checks;
    logic [15:0] val;
    logic [7:0]  junk;

    timer2_reload_capture uut (
        .pclk                 (pclk),
        .presetn              (presetn),
        .psel                 (psel),
        .penable              (penable),
        .pwrite               (pwrite),
        .paddr                (paddr),
        .pwdata               (pwdata),
        .prdata               (prdata),
        .pready               (pready),
        .pslverr              (pslverr),
        .external_trigger_pin (trig),
        .clock_out_pin        (clock_out_pin),
        .clock_out_oe         (clock_out_oe),
        .irq                  (irq)
    );

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // ----------------------------------------
    // Bus tasks and compares
    // ----------------------------------------
    task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: read got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: pin got %b expected %b", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h00_0000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a stalled wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata[7:0];
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d, junk);
    endtask

    task automatic rd_chk(input logic [9:0] idx, input logic [7:0] e, input logic err = 1'b0);
        exp_q.push_back({err, 24'h00_0000, e});
        apb(1'b0, idx, 8'h00, junk);
    endtask

    task automatic set_count(input logic [15:0] v);
        wr(COUNT_LOW_IDX, v[7:0]);
        wr(COUNT_HIGH_IDX, v[15:8]);
    endtask

    task automatic rd_count(input logic [15:0] v);
        rd_chk(COUNT_LOW_IDX, v[7:0]);
        rd_chk(COUNT_HIGH_IDX, v[15:8]);
    endtask

    task automatic unlock_write(input logic [7:0] d);
        wr(UNLOCK_IDX, UNLOCK_KEY_FIRST);
        wr(UNLOCK_IDX, UNLOCK_KEY_SECOND);
        wr(CLOCK_CONTROL_IDX, d);
    endtask

    // Run and stop edges lie k+3 cycles apart, so the tick count is exact
    task automatic run_window(input logic [7:0] ctrl, input int k);
        wr(TIMER_CONTROL_IDX, ctrl);
        repeat (k) @(posedge pclk);
        wr(TIMER_CONTROL_IDX, ctrl & 8'hfb);
    endtask

    task automatic pins(input logic oe, input logic cpin, input logic i);
        repeat (2) @(posedge pclk);
        chk_pin(clock_out_oe, oe);
        chk_pin(clock_out_pin, cpin);
        chk_pin(irq, i);
    endtask

    task automatic finish_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
            cmp({pslverr, prdata}, exp_q.pop_front());
    end

    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        finish_test();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        trig = 1'b1;
        miscompares = 0;
        checks = 0;
        void'($urandom(66));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) rd_chk(TIMER_MODE_IDX + 10'(i), 8'h00);
        rd_chk(CLOCK_CONTROL_IDX, CLOCK_CONTROL_RESET);
        rd_chk(IRQ_STATUS_IDX, 8'h00);
        rd_chk(10'h0ff, 8'h00, 1'b1);
        for (int i = 1; i < 5; i++) begin
            val = 16'($urandom);
            wr(TIMER_MODE_IDX + 10'(i), val[7:0]);
            rd_chk(TIMER_MODE_IDX + 10'(i), val[7:0]);
        end
        wr(TIMER_MODE_IDX, 8'hff);
        rd_chk(TIMER_MODE_IDX, 8'hff & TIMER_MODE_MASK);
        pins(1'b1, 1'b0, 1'b0);
        wr(TIMER_MODE_IDX, 8'h00);
        pins(1'b0, 1'b0, 1'b0);
        wr(CLOCK_CONTROL_IDX, 8'h38);
        rd_chk(CLOCK_CONTROL_IDX, CLOCK_CONTROL_RESET);
        unlock_write(8'h38);
        rd_chk(CLOCK_CONTROL_IDX, 8'h38);
        unlock_write(8'h01);
        set_count(16'h12fc);
        run_window(8'h04, 117);
        rd_count(16'h1310);
        repeat (20) @(posedge pclk);
        rd_count(16'h1310);
        unlock_write(8'h21);
        run_window(8'h04, 117);
        rd_count(16'h131a);
        unlock_write(8'h01);
        wr(OPTION_IDX, 8'h08);
        run_window(8'h04, 117);
        rd_count(16'h1324);
        val = 16'($urandom) & 16'h7fff;
        wr(CAP_LOW_IDX, val[7:0]);
        wr(CAP_HIGH_IDX, val[15:8]);
        wr(TIMER_MODE_IDX, 8'h02);
        set_count(16'hfffe);
        wr(IRQ_ENABLE_IDX, 8'h01);
        run_window(8'h04, 33);
        rd_count(val + 16'h0001);
        rd_chk(IRQ_STATUS_IDX, 8'h01);
        pins(1'b1, 1'b1, 1'b1);
        wr(IRQ_ENABLE_IDX, 8'h00);
        pins(1'b1, 1'b1, 1'b0);
        wr(IRQ_ENABLE_IDX, 8'h01);
        pins(1'b1, 1'b1, 1'b1);
        wr(IRQ_CLEAR_IDX, 8'h01);
        rd_chk(IRQ_STATUS_IDX, 8'h00);
        wr(TIMER_MODE_IDX, 8'h00);
        val = 16'($urandom);
        set_count(val);
        wr(TIMER_CONTROL_IDX, 8'h09);
        wr(IRQ_ENABLE_IDX, 8'h02);
        @(posedge pclk);
        trig <= 1'b0;
        repeat (8) @(posedge pclk);
        rd_chk(CAP_LOW_IDX, val[7:0]);
        rd_chk(CAP_HIGH_IDX, val[15:8]);
        rd_chk(IRQ_STATUS_IDX, 8'h02);
        pins(1'b0, 1'b0, 1'b1);
        wr(IRQ_CLEAR_IDX, 8'h02);
        trig <= 1'b1;
        set_count(16'h0000);
        wr(TIMER_CONTROL_IDX, 8'h08);
        @(posedge pclk);
        trig <= 1'b0;
        repeat (8) @(posedge pclk);
        rd_count(val);
        wr(TIMER_CONTROL_IDX, 8'h00);
        wr(CAP_LOW_IDX, 8'h00);
        wr(CAP_HIGH_IDX, 8'h00);
        wr(TIMER_MODE_IDX, 8'h01);
        set_count(16'h0010);
        run_window(8'h04, 33);
        rd_count(16'h000d);
        trig <= 1'b1;
        repeat (6) @(posedge pclk);
        run_window(8'h04, 33);
        rd_count(16'h0010);
        // down-count match loads all ones and flags
        wr(IRQ_CLEAR_IDX, 8'h03);
        wr(CAP_LOW_IDX, 8'h0f);
        trig <= 1'b0;
        repeat (6) @(posedge pclk);
        run_window(8'h04, 33);
        rd_count(16'hfffe);
        rd_chk(IRQ_STATUS_IDX, 8'h01);
        // counter mode counts trigger edges while running
        wr(TIMER_MODE_IDX, 8'h00);
        set_count(16'h0000);
        wr(TIMER_CONTROL_IDX, 8'h06);
        repeat (3) begin
            trig <= 1'b1;
            repeat (4) @(posedge pclk);
            trig <= 1'b0;
            repeat (4) @(posedge pclk);
        end
        wr(TIMER_CONTROL_IDX, 8'h00);
        rd_count(16'h0003);
        repeat (4) @(posedge pclk);
        finish_test();
    end
endmodule
